// ### logic/output_stage_control_regs.v
// Purpose: control registers for the analogue output section
// Assumes: one clock, speaker sign inputs are asynchronous and pass a two-flop synchroniser
// Notes:   decoded controls go to the analogue stages straight from flops
//
// Overview of operation
// - speaker volumes stay pending until update bit written; then both arm together
// - zero-cross enable set applies gain at zero crossing, else immediately
// - right speaker mute bit drives only the DC level
// - right speaker volume 6 bits, reset 111001 meaning 0dB
// - speaker boost select picks inverting x1 or non-inverting x1.5
// - beep enable passes aux input; 3-bit beep gain -15dB to +6dB
// - beep register bit 4 inverts right speaker, bit 5 mutes inverter main input
// - zero-cross timeout applies pending gain after 2^21 clocks with slow clock on
// - slow clock enable defaults 0 and clocks the zero-cross timeout
// - left line mixer sums selected sources, bit 0 resets to 1
// - line mixer bit 6 mutes stage and drives mid rail reference
// - right line mixer sums selected sources, bit 0 resets to 1
// - right line mixer bit 5 attenuates output by 6dB
// - output control bits 3 and 4 select line output boost
// - unboosted stage inverts; right speaker beep inverter adds one more
// - DAC polarity bits invert the corresponding DAC output
// - every output and mixer enable resets to 0
// - power one holds tie-off, line mixer and level-shift enables
// - power two sleep and headphones; power three mixers and speakers
// - left speaker volume register mirrors the right one
`timescale 1ns/1ns
`include "out_stage_consts.vh"
module output_stage_control_regs (
  input  wire                  clk_i,
  input  wire                  rst_n_i,
  input  wire                  clk_en_i,
  input  wire [`ADDR_W-1:0]    addr_i,
  input  wire [`DATA_W-1:0]    wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [`DATA_W-1:0]    rdata_o,
  input  wire                  left_speaker_sign_i,
  input  wire                  right_speaker_sign_i,
  output reg  [5:0]            left_speaker_gain_o,
  output reg  [5:0]            right_speaker_gain_o,
  output reg                   left_speaker_mute_o,
  output reg                   right_speaker_mute_o,
  output reg                   speaker_boost_sel_o,
  output reg                   left_line_boost_sel_o,
  output reg                   right_line_boost_sel_o,
  output reg                   left_speaker_invert_o,
  output reg                   right_speaker_invert_o,
  output reg                   left_line_invert_o,
  output reg                   right_line_invert_o,
  output reg                   left_dac_polarity_o,
  output reg                   right_dac_polarity_o,
  output reg                   beep_input_en_o,
  output reg  [2:0]            beep_gain_o,
  output reg                   inverter_main_input_mute_o,
  output reg                   slow_clock_en_o,
  output reg  [3:0]            left_line_sources_o,
  output reg  [3:0]            right_line_sources_o,
  output reg                   left_line_mute_o,
  output reg                   right_line_mute_o,
  output reg                   right_line_attenuate_o,
  output reg                   tie_off_buffer_en_o,
  output reg                   left_line_mixer_en_o,
  output reg                   right_line_mixer_en_o,
  output reg                   level_shift_buffer_en_o,
  output reg                   sleep_o,
  output reg                   left_headphone_en_o,
  output reg                   right_headphone_en_o,
  output reg                   left_output_mixer_en_o,
  output reg                   right_output_mixer_en_o,
  output reg                   right_speaker_en_o,
  output reg                   left_speaker_en_o
);

////////////////////////////////////////////////////////////////////////////////
// register storage
reg  [`DATA_W-1:0] pwr1_r;
reg  [`DATA_W-1:0] pwr2_r;
reg  [`DATA_W-1:0] pwr3_r;
reg  [`DATA_W-1:0] addctl_r;
reg  [`DATA_W-1:0] beep_r;
reg  [`DATA_W-1:0] outctl_r;
reg  [`DATA_W-1:0] llmix_r;
reg  [`DATA_W-1:0] rlmix_r;
reg  [7:0]         spk_pend_r [0:1];
reg  [1:0]         spk_armed_r;
reg  [1:0]         sign_s1_r;
reg  [1:0]         sign_s2_r;
reg  [1:0]         sign_prev_r;
reg  [`TMO_W-1:0]  tmo_cnt_r [0:1];
reg  [5:0]         gain_r [0:1];

function hit;
  input [`ADDR_W-1:0] a;
  input [`ADDR_W-1:0] ofs;
  begin
    hit = wr_i && (a == ofs);
  end
endfunction

wire wr_lspk   = hit(addr_i, `OFS_LSPK);
wire wr_rspk   = hit(addr_i, `OFS_RSPK);
wire wr_pwr1   = hit(addr_i, `OFS_PWR1);
wire wr_pwr2   = hit(addr_i, `OFS_PWR2);
wire wr_pwr3   = hit(addr_i, `OFS_PWR3);
wire wr_addctl = hit(addr_i, `OFS_ADDCTL);
wire wr_beep   = hit(addr_i, `OFS_BEEP);
wire wr_outctl = hit(addr_i, `OFS_OUTCTL);
wire wr_llmix  = hit(addr_i, `OFS_LLMIX);
wire wr_rlmix  = hit(addr_i, `OFS_RLMIX);
wire vu_hit    = (wr_lspk | wr_rspk) & wdata_i[`BIT_VU];

////////////////////////////////////////////////////////////////////////////////
// plain registers, reserved bits masked off
always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    pwr1_r <= `RST_ZERO;
  else if (clk_en_i && wr_pwr1)
    pwr1_r <= wdata_i & `MASK_PWR1;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    pwr2_r <= `RST_ZERO;
  else if (clk_en_i && wr_pwr2)
    pwr2_r <= wdata_i & `MASK_PWR2;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    pwr3_r <= `RST_ZERO;
  else if (clk_en_i && wr_pwr3)
    pwr3_r <= wdata_i & `MASK_PWR3;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    addctl_r <= `RST_ZERO;
  else if (clk_en_i && wr_addctl)
    addctl_r <= wdata_i & `MASK_ADDCTL;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    beep_r <= `RST_ZERO;
  else if (clk_en_i && wr_beep)
    beep_r <= wdata_i & `MASK_BEEP;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    outctl_r <= `RST_ZERO;
  else if (clk_en_i && wr_outctl)
    outctl_r <= wdata_i & `MASK_OUTCTL;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    llmix_r <= `RST_LLMIX;
  else if (clk_en_i && wr_llmix)
    llmix_r <= wdata_i & `MASK_LLMIX;
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    rlmix_r <= `RST_RLMIX;
  else if (clk_en_i && wr_rlmix)
    rlmix_r <= wdata_i & `MASK_RLMIX;
end

////////////////////////////////////////////////////////////////////////////////
// speaker volume: pending value, arm on update, apply at zero cross or timeout
genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : spk
    wire wr_me   = (g == 0) ? wr_lspk : wr_rspk;
    wire zc_en   = spk_pend_r[g][`BIT_ZC];
    wire crossed = sign_s2_r[g] ^ sign_prev_r[g];
    wire tmo_hit = addctl_r[`BIT_SLOWCLK] & tmo_cnt_r[g][`TIMEOUT_LOG2];
    always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        spk_pend_r[g]  <= {2'h0, `RST_SPK_VOL};
        spk_armed_r[g] <= 1'b0;
        tmo_cnt_r[g]   <= {`TMO_W{1'b0}};
        gain_r[g]      <= `RST_SPK_VOL;
      end else if (clk_en_i) begin
        if (wr_me)
          spk_pend_r[g] <= wdata_i[`PEND_HI:0];
        if (vu_hit) begin
          spk_armed_r[g] <= 1'b1;
          tmo_cnt_r[g]   <= {`TMO_W{1'b0}};
        end else if (spk_armed_r[g]) begin
          if (!zc_en || crossed || tmo_hit) begin
            gain_r[g]      <= spk_pend_r[g][`VOL_HI:0];
            spk_armed_r[g] <= 1'b0;
          end else if (addctl_r[`BIT_SLOWCLK]) begin
            tmo_cnt_r[g] <= tmo_cnt_r[g] + 1'b1;
          end
        end
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// sign inputs come from the analogue side, synchronised first
always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    sign_s1_r   <= 2'h0;
    sign_s2_r   <= 2'h0;
    sign_prev_r <= 2'h0;
  end else if (clk_en_i) begin
    sign_s1_r   <= {right_speaker_sign_i, left_speaker_sign_i};
    sign_s2_r   <= sign_s1_r;
    sign_prev_r <= sign_s2_r;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe, unmapped reads zero
reg [`DATA_W-1:0] rd_nxt;
always @* begin
  case (addr_i)
    `OFS_PWR1:   rd_nxt = pwr1_r;
    `OFS_PWR2:   rd_nxt = pwr2_r;
    `OFS_PWR3:   rd_nxt = pwr3_r;
    `OFS_ADDCTL: rd_nxt = addctl_r;
    `OFS_BEEP:   rd_nxt = beep_r;
    `OFS_OUTCTL: rd_nxt = outctl_r;
    `OFS_LSPK:   rd_nxt = {1'b0, spk_pend_r[0]};
    `OFS_RSPK:   rd_nxt = {1'b0, spk_pend_r[1]};
    `OFS_LLMIX:  rd_nxt = llmix_r;
    `OFS_RLMIX:  rd_nxt = rlmix_r;
    default:     rd_nxt = `RST_ZERO;
  endcase
end

// read data register, holds until the next read
always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i)
    rdata_o <= `RST_ZERO;
  else if (clk_en_i && rd_i)
    rdata_o <= rd_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// decoded controls, all outputs registered
always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    left_speaker_gain_o        <= `RST_SPK_VOL;
    right_speaker_gain_o       <= `RST_SPK_VOL;
    left_speaker_mute_o        <= 1'b0;
    right_speaker_mute_o       <= 1'b0;
    speaker_boost_sel_o        <= 1'b0;
    left_line_boost_sel_o      <= 1'b0;
    right_line_boost_sel_o     <= 1'b0;
    left_speaker_invert_o      <= 1'b1;
    right_speaker_invert_o     <= 1'b1;
    left_line_invert_o         <= 1'b1;
    right_line_invert_o        <= 1'b1;
    left_dac_polarity_o        <= 1'b0;
    right_dac_polarity_o       <= 1'b0;
    beep_input_en_o            <= 1'b0;
    beep_gain_o                <= 3'h0;
    inverter_main_input_mute_o <= 1'b0;
    slow_clock_en_o            <= 1'b0;
    left_line_sources_o        <= `RST_SRC;
    right_line_sources_o       <= `RST_SRC;
    left_line_mute_o           <= 1'b0;
    right_line_mute_o          <= 1'b0;
    right_line_attenuate_o     <= 1'b0;
    tie_off_buffer_en_o        <= 1'b0;
    left_line_mixer_en_o       <= 1'b0;
    right_line_mixer_en_o      <= 1'b0;
    level_shift_buffer_en_o    <= 1'b0;
    sleep_o                    <= 1'b0;
    left_headphone_en_o        <= 1'b0;
    right_headphone_en_o       <= 1'b0;
    left_output_mixer_en_o     <= 1'b0;
    right_output_mixer_en_o    <= 1'b0;
    right_speaker_en_o         <= 1'b0;
    left_speaker_en_o          <= 1'b0;
  end else if (clk_en_i) begin
    left_speaker_gain_o        <= gain_r[0];
    right_speaker_gain_o       <= gain_r[1];
    left_speaker_mute_o        <= spk_pend_r[0][`BIT_MUTE];
    right_speaker_mute_o       <= spk_pend_r[1][`BIT_MUTE];
    speaker_boost_sel_o        <= outctl_r[`BIT_SPEAKER_BOOST_SEL];
    left_line_boost_sel_o      <= outctl_r[`BIT_LLBOOST];
    right_line_boost_sel_o     <= outctl_r[`BIT_RLBOOST];
    // output stage inversion: unboosted inverts, right speaker beep inverter adds one
    left_speaker_invert_o      <= ~outctl_r[`BIT_SPEAKER_BOOST_SEL];
    right_speaker_invert_o     <= ~outctl_r[`BIT_SPEAKER_BOOST_SEL] ^ beep_r[`BIT_INVROUT];
    left_line_invert_o         <= ~outctl_r[`BIT_LLBOOST];
    right_line_invert_o        <= ~outctl_r[`BIT_RLBOOST];
    left_dac_polarity_o        <= outctl_r[`BIT_LDACPOL];
    right_dac_polarity_o       <= outctl_r[`BIT_RDACPOL];
    beep_input_en_o            <= beep_r[`BIT_BEEP_INPUT_EN];
    beep_gain_o                <= beep_r[`BEEP_HI:`BEEP_LO];
    inverter_main_input_mute_o <= beep_r[`BIT_INVMUTE];
    slow_clock_en_o            <= addctl_r[`BIT_SLOWCLK];
    left_line_sources_o        <= llmix_r[`SRC_HI:0];
    right_line_sources_o       <= {rlmix_r[`RSRC_HI:`RSRC_MID], rlmix_r[`RSRC_LO:0]};
    left_line_mute_o           <= llmix_r[`BIT_MUTE];
    right_line_mute_o          <= rlmix_r[`BIT_MUTE];
    right_line_attenuate_o     <= rlmix_r[`BIT_HALF];
    tie_off_buffer_en_o        <= pwr1_r[`BIT_TIEOFF];
    left_line_mixer_en_o       <= pwr1_r[`BIT_LLMIXEN];
    right_line_mixer_en_o      <= pwr1_r[`BIT_RLMIXEN];
    level_shift_buffer_en_o    <= pwr1_r[`BIT_LVLSHIFT];
    sleep_o                    <= pwr2_r[`BIT_SLEEP];
    left_headphone_en_o        <= pwr2_r[`BIT_LHP];
    right_headphone_en_o       <= pwr2_r[`BIT_RHP];
    left_output_mixer_en_o     <= pwr3_r[`BIT_LEFT_OUTPUT_MIXER_EN];
    right_output_mixer_en_o    <= pwr3_r[`BIT_RIGHT_OUTPUT_MIXER_EN];
    right_speaker_en_o         <= pwr3_r[`BIT_RSPKEN];
    left_speaker_en_o          <= pwr3_r[`BIT_LSPKEN];
  end
end

endmodule

// ### logic/out_stage_consts.vh
// Purpose: constants for the output stage control registers
// Assumes: 9-bit registers on a plain address/strobe port
// Notes:   offsets are register indices on the plain port
`ifndef OUT_STAGE_CONSTS_VH
`define OUT_STAGE_CONSTS_VH
`define ADDR_W            7
`define DATA_W            9
`define OFS_PWR1          7'h01
`define OFS_PWR2          7'h02
`define OFS_PWR3          7'h03
`define OFS_ADDCTL        7'h07
`define OFS_BEEP          7'h2B
`define OFS_OUTCTL        7'h31
`define OFS_LSPK          7'h36
`define OFS_RSPK          7'h37
`define OFS_LLMIX         7'h38
`define OFS_RLMIX         7'h39
`define RST_ZERO          9'h000
`define RST_SPK_VOL       6'h39
`define RST_LLMIX         9'h001
`define RST_RLMIX         9'h001
`define BIT_VU            8
`define BIT_ZC            7
`define BIT_MUTE          6
`define VOL_HI            5
`define BIT_SLOWCLK       0
`define BIT_SPEAKER_BOOST_SEL      2
`define BIT_LLBOOST       3
`define BIT_RLBOOST       4
`define BIT_LDACPOL       5
`define BIT_RDACPOL       6
`define MASK_PWR1         9'h1C4
`define MASK_PWR2         9'h1C0
`define MASK_PWR3         9'h06C
`define MASK_ADDCTL       9'h001
`define MASK_BEEP         9'h03F
`define MASK_OUTCTL       9'h07C
`define MASK_LLMIX        9'h04F
`define MASK_RLMIX        9'h07B
`define PEND_HI           7
`define BIT_BEEP_INPUT_EN        0
`define BEEP_HI           3
`define BEEP_LO           1
`define BIT_INVROUT       4
`define BIT_INVMUTE       5
`define BIT_HALF          5
`define SRC_HI            3
`define RSRC_HI           4
`define RSRC_MID          3
`define RSRC_LO           1
`define RST_SRC           4'h1
`define BIT_TIEOFF        2
`define BIT_LLMIXEN       6
`define BIT_RLMIXEN       7
`define BIT_LVLSHIFT      8
`define BIT_SLEEP         6
`define BIT_LHP           7
`define BIT_RHP           8
`define BIT_LEFT_OUTPUT_MIXER_EN        2
`define BIT_RIGHT_OUTPUT_MIXER_EN        3
`define BIT_RSPKEN        5
`define BIT_LSPKEN        6
`define TIMEOUT_LOG2      21
`define TMO_W             22
`endif

// ### verification/output_stage_control_asserts.sv
// Purpose: port-level assertions for the output stage control registers
// Assumes: clk_en_i is high while requests are checked
// Notes:   bound to the design at the foot of this file
`timescale 1ns/1ns
`include "out_stage_consts.vh"
module output_stage_control_asserts (
  input wire               clk_i,
  input wire               rst_n_i,
  input wire               clk_en_i,
  input wire [`ADDR_W-1:0] addr_i,
  input wire [`DATA_W-1:0] wdata_i,
  input wire               wr_i,
  input wire               rd_i,
  input wire [`DATA_W-1:0] rdata_o,
  input wire [5:0]         left_speaker_gain_o,
  input wire [5:0]         right_speaker_gain_o,
  input wire               right_speaker_mute_o,
  input wire               speaker_boost_sel_o,
  input wire               left_line_boost_sel_o,
  input wire               left_speaker_invert_o,
  input wire               left_line_invert_o,
  input wire               beep_input_en_o,
  input wire [2:0]         beep_gain_o,
  input wire [3:0]         right_line_sources_o,
  input wire               left_output_mixer_en_o,
  input wire               right_output_mixer_en_o,
  input wire               right_speaker_en_o,
  input wire               left_speaker_en_o
);
  reg  vu_seen_r;
  wire wr_ok = wr_i && clk_en_i;
  ////////////////////////////////////////////////////////////////////////////////
  // sticky flag: some speaker update write has been taken since reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      vu_seen_r <= 1'b0;
    else if (wr_ok && wdata_i[`BIT_VU] && (addr_i == `OFS_RSPK || addr_i == `OFS_LSPK))
      vu_seen_r <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_gain_reset_hold:
  assert property (!vu_seen_r |-> right_speaker_gain_o == 6'h39 && left_speaker_gain_o == 6'h39)
    else $error("speaker gain moved before any update write");
  a_gain_direct_apply:
  assert property (wr_ok && addr_i == `OFS_RSPK && wdata_i[8] && !wdata_i[7]
                   |-> ##3 right_speaker_gain_o == $past(wdata_i[5:0], 3))
    else $error("right gain not applied after immediate update");
  a_mute_direct:
  assert property (wr_ok && addr_i == `OFS_RSPK |-> ##2 right_speaker_mute_o == $past(wdata_i[6], 2))
    else $error("right speaker mute does not follow its bit");
  a_boost_follows:
  assert property (wr_ok && addr_i == `OFS_OUTCTL |-> ##2 speaker_boost_sel_o == $past(wdata_i[2], 2))
    else $error("speaker boost select does not follow its bit");
  a_beep_fields:
  assert property (wr_ok && addr_i == `OFS_BEEP
                   |-> ##2 {beep_gain_o, beep_input_en_o} == $past(wdata_i[3:0], 2))
    else $error("beep gain or enable does not follow the register");
  a_phase_invert:
  assert property (left_speaker_invert_o == !speaker_boost_sel_o && left_line_invert_o == !left_line_boost_sel_o)
    else $error("output inversion disagrees with boost select");
  a_right_sources:
  assert property (wr_ok && addr_i == `OFS_RLMIX
                   |-> ##2 right_line_sources_o == {$past(wdata_i[4:3], 2), $past(wdata_i[1:0], 2)})
    else $error("right line sources do not follow the register");
  a_power_three:
  assert property (wr_ok && addr_i == `OFS_PWR3 |-> ##2 {left_speaker_en_o, right_speaker_en_o,
                   right_output_mixer_en_o, left_output_mixer_en_o} ==
                   {$past(wdata_i[6:5], 2), $past(wdata_i[3:2], 2)})
    else $error("power three enables do not follow the register");
  a_read_reserved:
  assert property (rd_i && clk_en_i && addr_i == `OFS_LLMIX |=> rdata_o[8:7] == 2'h0 && rdata_o[5:4] == 2'h0)
    else $error("reserved left line mixer bits read nonzero");
endmodule
bind output_stage_control_regs output_stage_control_asserts u_chk (.clk_i, .rst_n_i, .clk_en_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .left_speaker_gain_o, .right_speaker_gain_o, .right_speaker_mute_o,
  .speaker_boost_sel_o, .left_line_boost_sel_o, .left_speaker_invert_o, .left_line_invert_o,
  .beep_input_en_o, .beep_gain_o, .right_line_sources_o, .left_output_mixer_en_o,
  .right_output_mixer_en_o, .right_speaker_en_o, .left_speaker_en_o);

// ### verification/output_stage_control_regs_tb.sv
// Purpose: self-checking bench for the output stage control registers
// Assumes: clock enable held high except around one gated beep write near the end
// Notes:   zero-cross timeout is far beyond the run length and is not waited out
`timescale 1ns/1ns
`include "out_stage_consts.vh"
module output_stage_control_regs_tb;
  reg        clk_i, rst_n_i, clk_en_i, wr_i, rd_i, left_speaker_sign_i, right_speaker_sign_i;
  reg  [6:0] addr_i;
  reg  [8:0] wdata_i;
  wire [8:0] rdata_o;
  wire [5:0] left_speaker_gain_o, right_speaker_gain_o;
  wire [2:0] beep_gain_o;
  wire [3:0] left_line_sources_o, right_line_sources_o;
  wire       left_speaker_mute_o, right_speaker_mute_o, speaker_boost_sel_o, left_line_boost_sel_o;
  wire       right_line_boost_sel_o, left_speaker_invert_o, right_speaker_invert_o, left_line_invert_o;
  wire       right_line_invert_o, left_dac_polarity_o, right_dac_polarity_o, beep_input_en_o;
  wire       inverter_main_input_mute_o, slow_clock_en_o, left_line_mute_o, right_line_mute_o;
  wire       right_line_attenuate_o, tie_off_buffer_en_o, left_line_mixer_en_o, right_line_mixer_en_o;
  wire       level_shift_buffer_en_o, sleep_o, left_headphone_en_o, right_headphone_en_o;
  wire       left_output_mixer_en_o, right_output_mixer_en_o, right_speaker_en_o, left_speaker_en_o;
  integer    fails, comparisons, i;
  wire [8:0] pwr_v = {level_shift_buffer_en_o, right_line_mixer_en_o, left_line_mixer_en_o, tie_off_buffer_en_o,
    right_headphone_en_o, left_headphone_en_o, sleep_o, right_output_mixer_en_o, left_output_mixer_en_o};
  wire [8:0] ctl_v = {right_speaker_en_o, left_speaker_en_o, speaker_boost_sel_o, left_line_boost_sel_o,
    right_line_boost_sel_o, left_dac_polarity_o, right_dac_polarity_o, slow_clock_en_o, inverter_main_input_mute_o};
  wire [8:0] mix_v = {beep_input_en_o, beep_gain_o, left_line_mute_o, right_line_mute_o, right_line_attenuate_o,
    left_speaker_mute_o, right_speaker_mute_o};
  wire [8:0] inv_v = {5'h00, left_speaker_invert_o, right_speaker_invert_o, left_line_invert_o, right_line_invert_o};
  wire [8:0] src_v = {1'b0, left_line_sources_o, right_line_sources_o};
  localparam logic [6:0] OFS [10] = '{`OFS_PWR1, `OFS_PWR2, `OFS_PWR3, `OFS_ADDCTL, `OFS_BEEP, `OFS_OUTCTL,
    `OFS_LSPK, `OFS_RSPK, `OFS_LLMIX, `OFS_RLMIX};
  localparam logic [8:0] RST [10] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h039, 9'h039, 9'h001, 9'h001};
  localparam logic [8:0] WRV [10] = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h07F, 9'h07F, 9'h1FF, 9'h1FF};
  localparam logic [8:0] RDV [10] = '{`MASK_PWR1, `MASK_PWR2, `MASK_PWR3, `MASK_ADDCTL, `MASK_BEEP, `MASK_OUTCTL,
    9'h07F, 9'h07F, `MASK_LLMIX, `MASK_RLMIX};
  output_stage_control_regs dut (.clk_i, .rst_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .left_speaker_sign_i, .right_speaker_sign_i, .left_speaker_gain_o, .right_speaker_gain_o, .left_speaker_mute_o,
    .right_speaker_mute_o, .speaker_boost_sel_o, .left_line_boost_sel_o, .right_line_boost_sel_o,
    .left_speaker_invert_o, .right_speaker_invert_o, .left_line_invert_o, .right_line_invert_o,
    .left_dac_polarity_o, .right_dac_polarity_o, .beep_input_en_o, .beep_gain_o, .inverter_main_input_mute_o,
    .slow_clock_en_o, .left_line_sources_o, .right_line_sources_o, .left_line_mute_o, .right_line_mute_o,
    .right_line_attenuate_o, .tie_off_buffer_en_o, .left_line_mixer_en_o, .right_line_mixer_en_o,
    .level_shift_buffer_en_o, .sleep_o, .left_headphone_en_o, .right_headphone_en_o, .left_output_mixer_en_o,
    .right_output_mixer_en_o, .right_speaker_en_o, .left_speaker_en_o);
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rchk(input logic [6:0] a, input logic [8:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", e, rdata_o);
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_i, rst_n_i, wr_i, rd_i, left_speaker_sign_i, right_speaker_sign_i} = 6'h00;
    clk_en_i = 1'b1;
    addr_i = 7'h00;
    wdata_i = 9'h000;
    fails = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(1);
    chk("gains", 9'h039, {3'h0, right_speaker_gain_o});
    chk("left gain", 9'h039, {3'h0, left_speaker_gain_o});
    chk("power", 9'h000, pwr_v);
    chk("controls", 9'h000, ctl_v);
    chk("mix", 9'h000, mix_v);
    chk("invert", 9'h00F, inv_v);
    chk("sources", 9'h011, src_v);
    for (i = 0; i < 10; i = i + 1) rchk(OFS[i], RST[i]);
    for (i = 0; i < 10; i = i + 1) wr(OFS[i], WRV[i]);
    wr(7'h7F, 9'h1FF);
    for (i = 0; i < 10; i = i + 1) rchk(OFS[i], RDV[i]);
    rchk(7'h7F, 9'h000);
    chk("power", 9'h1FF, pwr_v);
    chk("controls", 9'h1FF, ctl_v);
    chk("mix", 9'h1FF, mix_v);
    chk("invert", 9'h004, inv_v);
    chk("sources", 9'h0FF, src_v);
    chk("gains", 9'h039, {3'h0, right_speaker_gain_o});
    wr(`OFS_OUTCTL, 9'h000);
    idle(3);
    chk("invert", 9'h00B, inv_v);
    wr(`OFS_RSPK, 9'h010);
    idle(4);
    chk("gains", 9'h039, {3'h0, right_speaker_gain_o});
    wr(`OFS_LSPK, 9'h105);
    idle(4);
    chk("gains", 9'h010, {3'h0, right_speaker_gain_o});
    chk("left gain", 9'h005, {3'h0, left_speaker_gain_o});
    chk("mix", 9'h1FC, mix_v);
    wr(`OFS_RSPK, 9'h1A0);
    idle(8);
    chk("gains", 9'h010, {3'h0, right_speaker_gain_o});
    @(posedge clk_i);
    right_speaker_sign_i <= 1'b1;
    idle(6);
    chk("gains", 9'h020, {3'h0, right_speaker_gain_o});
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    wr(`OFS_BEEP, 9'h000);
    idle(2);
    chk("mix", 9'h1FC, mix_v);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    idle(2);
    chk("mix", 9'h1FC, mix_v);
    results;
  end
endmodule
